// ==== src/radio_irq_pkg.sv ====
// Shared constants, types and helpers for the radio interrupt, pin and modulation control block
package radio_irq_pkg;
    // Property addresses as {group, index}
    localparam logic [15:0] PROP_GROUP_EN    = 16'h0100;
    localparam logic [15:0] PROP_PACKET_EN   = 16'h0101;
    localparam logic [15:0] PROP_MODEM_EN    = 16'h0102;
    localparam logic [15:0] PROP_CHIP_EN     = 16'h0103;
    localparam logic [15:0] PROP_MODULATION  = 16'h2000;

    // Values after reset
    localparam logic [7:0]  RST_GROUP_EN     = 8'h04;
    localparam logic [7:0]  RST_PACKET_EN    = 8'h00;
    localparam logic [7:0]  RST_MODEM_EN     = 8'h00;
    localparam logic [7:0]  RST_CHIP_EN      = 8'h04;
    localparam logic [7:0]  RST_MODULATION   = 8'h02;
    localparam logic [1:0]  RST_DRIVE        = 2'h0;

    // Command codes
    localparam logic [7:0]  CMD_NONE         = 8'h00;
    localparam logic [7:0]  CMD_SET_PROP     = 8'h11;
    localparam logic [7:0]  CMD_GET_PROP     = 8'h12;
    localparam logic [7:0]  CMD_PIN_CFG      = 8'h13;
    localparam logic [7:0]  CMD_READ_ALL     = 8'h20;
    localparam logic [7:0]  CMD_READ_PACKET  = 8'h21;
    localparam logic [7:0]  CMD_READ_MODEM   = 8'h22;
    localparam logic [7:0]  CMD_READ_CHIP    = 8'h23;
    localparam logic [7:0]  CMD_QUICK_STATUS = 8'h50;

    // Bit positions of the group enables
    localparam int          GRP_PACKET_BIT   = 0;
    localparam int          GRP_MODEM_BIT    = 1;
    localparam int          GRP_CHIP_BIT     = 2;

    // Fields of modulation_config
    localparam int          KEY_LSB          = 0;
    localparam int          KEY_MSB          = 2;
    localparam int          ORIGIN_LSB       = 3;
    localparam int          ORIGIN_MSB       = 4;
    localparam int          DPIN_LSB         = 5;
    localparam int          DPIN_MSB         = 6;
    localparam int          DASYNC_BIT       = 7;
    // Drive strength field in the pin-configuration byte
    localparam int          DRIVE_LSB        = 5;
    localparam int          DRIVE_MSB        = 6;

    // Frame byte positions
    localparam logic [3:0]  IDX_CTS          = 4'h1;
    localparam logic [3:0]  IDX_DATA         = 4'h2;
    localparam logic [3:0]  IDX_START        = 4'h3;
    localparam logic [3:0]  IDX_WDATA        = 4'h4;
    localparam logic [3:0]  IDX_PROP_DATA    = 4'h5;
    localparam logic [3:0]  IDX_DRIVE        = 4'h5;
    localparam logic [3:0]  IDX_LAST         = 4'hf;

    typedef enum logic [2:0] {
        KEY_CW    = 3'b000,
        KEY_OOK   = 3'b001,
        KEY_FSK2  = 3'b010,
        KEY_GFSK2 = 3'b011,
        KEY_FSK4  = 3'b100,
        KEY_GFSK4 = 3'b101
    } keying_t;

    typedef enum logic [1:0] {
        ORIGIN_FIFO   = 2'b00,
        ORIGIN_DIRECT = 2'b01,
        ORIGIN_PRBS   = 2'b10
    } origin_t;

    typedef enum logic [5:0] {
        PIN_TRISTATE = 6'h01,
        PIN_DRIVE0   = 6'h02,
        PIN_DRIVE1   = 6'h03,
        PIN_INPUT    = 6'h04,
        PIN_POR      = 6'h07,
        PIN_CTS      = 6'h08,
        PIN_EVENT    = 6'h09
    } pin_fn_t;

    function automatic logic [3:0] bin2gray(input logic [3:0] b);
        return b ^ {1'b0, b[3:1]};
    endfunction

    function automatic logic [3:0] gray2bin(input logic [3:0] g);
        logic [3:0] b;
        b[3] = g[3];
        for (int i = 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction
endpackage

// ==== src/radio_irq_gpio_mod_config.sv ====
// Host command port, event latching, pin control and modulation setup of the radio
`timescale 1ns/1ps

module radio_link_port (
    input  wire logic             i_sclk,     // Host serial clock
    input  wire logic             i_cs_n,     // Frame select, low in a frame
    input  wire logic             i_sdi,      // Serial data from host
    input  wire logic [15:0][7:0] i_resp,     // Response bytes, stable per byte
    output logic      [7:0]       o_rx_byte,  // Last whole byte received
    output logic      [3:0]       o_gray,     // Gray count of bytes received
    output logic                  o_sdo       // Serial data to host
);
    typedef struct packed {
        logic [2:0] bit_cnt;
        logic [3:0] byte_cnt;
        logic [6:0] shreg;
        logic [7:0] rx_byte;
        logic [3:0] gray;
    } link_t;

    localparam link_t LINK_RST = '0;

    link_t link_reg;
    link_t link_next;

    // The host clock stops between frames, so the frame select clears the counters
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            link_reg <= LINK_RST;
        end else begin
            link_reg <= link_next;
        end
    end

    always_comb begin
        link_next         = link_reg;
        link_next.shreg   = {link_reg.shreg[5:0], i_sdi};
        link_next.bit_cnt = link_reg.bit_cnt + 3'h1;
        // Saturate so the gray count never wraps back onto a stale value
        if (link_reg.bit_cnt == 3'h7 && link_reg.byte_cnt != radio_irq_pkg::IDX_LAST) begin
            link_next.rx_byte  = {link_reg.shreg, i_sdi};
            link_next.byte_cnt = link_reg.byte_cnt + 4'h1;
            link_next.gray     = radio_irq_pkg::bin2gray(link_next.byte_cnt);
        end
    end

    assign o_rx_byte = link_reg.rx_byte;
    assign o_gray    = link_reg.gray;
    assign o_sdo     = i_resp[link_reg.byte_cnt][3'h7 - link_reg.bit_cnt];
endmodule

module radio_irq_gpio_mod_config (
    input  wire logic       i_clk,              // Core clock, 40 MHz
    input  wire logic       i_rst,              // Synchronous reset, active high
    input  wire logic       i_sclk,             // Host serial clock
    input  wire logic       i_cs_n,             // Host frame select, active low
    input  wire logic       i_serial_in_pin,    // Host serial data in
    output logic            o_serial_out_pin,   // Serial data out
    output logic            o_serial_out_oe_n,  // Serial out enable, low drives
    input  wire logic       i_shutdown_pin,     // Shutdown request, high
    input  wire logic       i_seq_busy,         // Sequencer stepping a transition
    input  wire logic [7:0] i_packet_event,     // Packet handler event pulses
    input  wire logic [7:0] i_modem_event,      // Modem event pulses
    input  wire logic [7:0] i_chip_event,       // Chip event pulses
    input  wire logic [7:0] i_packet_status,    // Packet handler live status
    input  wire logic [7:0] i_modem_status,     // Modem live status
    input  wire logic [7:0] i_chip_status,      // Chip live status
    output logic            o_event_out_n,      // Interrupt pin level, active low
    output logic            o_event_out_oe_n,   // Interrupt pin enable, low drives
    input  wire logic [3:0] i_gpio,             // Pin levels
    output logic      [3:0] o_gpio,             // Pin drive values
    output logic      [3:0] o_gpio_oe_n,        // Pin enables, low drives
    output logic      [1:0] o_gpio_drive,       // Pin drive strength
    output logic            o_cts,              // Command-accept flag
    output logic      [2:0] o_keying_scheme,    // Selected keying
    output logic      [1:0] o_tx_data_origin,   // Transmit data origin
    output logic      [1:0] o_tx_direct_pin,    // Direct-mode data pin
    output logic            o_tx_direct_async,  // Direct mode asynchronous
    output logic            o_tx_direct_data,   // Direct-mode data bit
    output logic            o_mod_unsupported   // Modulation setting not usable
);
    typedef struct packed {
        logic [3:0]       gpio_s1;
        logic [3:0]       gpio_s2;
        logic             sdn_s1;
        logic             sdn_s2;
        logic             cs_s1;
        logic             cs_s2;
        logic [3:0]       cnt_s1;
        logic [3:0]       cnt_s2;
        logic [3:0]       done;
        logic [3:0]       idx;
        logic [7:0]       cmd;
        logic [7:0]       grp;
        logic [7:0]       start;
        logic [7:0]       group_en;
        logic [7:0]       packet_en;
        logic [7:0]       modem_en;
        logic [7:0]       chip_en;
        logic [7:0]       modulation;
        logic [1:0]       drive;
        logic [3:0][5:0]  pin_fn;
        logic [7:0]       packet_pend;
        logic [7:0]       modem_pend;
        logic [7:0]       chip_pend;
        logic [15:0][7:0] resp;
        logic             por_done;
        logic             event_n;
        logic [3:0]       gpio_out;
        logic [3:0]       gpio_oe_n;
    } core_t;

    localparam core_t CORE_RST = '{
        group_en:   radio_irq_pkg::RST_GROUP_EN,
        packet_en:  radio_irq_pkg::RST_PACKET_EN,
        modem_en:   radio_irq_pkg::RST_MODEM_EN,
        chip_en:    radio_irq_pkg::RST_CHIP_EN,
        modulation: radio_irq_pkg::RST_MODULATION,
        drive:      radio_irq_pkg::RST_DRIVE,
        pin_fn:     {radio_irq_pkg::PIN_POR, radio_irq_pkg::PIN_POR,
                     radio_irq_pkg::PIN_CTS, radio_irq_pkg::PIN_POR},
        cs_s1:      1'b1,
        cs_s2:      1'b1,
        event_n:    1'b1,
        gpio_oe_n:  4'hf,
        default:    '0
    };

    core_t      core_reg;
    core_t      core_next;
    logic [7:0] rx_byte;
    logic [3:0] rx_gray;
    logic       cts;

    radio_link_port u_link (
        .i_sclk    (i_sclk),
        .i_cs_n    (i_cs_n),
        .i_sdi     (i_serial_in_pin),
        .i_resp    (core_reg.resp),
        .o_rx_byte (rx_byte),
        .o_gray    (rx_gray),
        .o_sdo     (o_serial_out_pin)
    );

    function automatic logic [7:0] prop_read(input core_t c, input logic [15:0] addr);
        case (addr)
            radio_irq_pkg::PROP_GROUP_EN:   return c.group_en;
            radio_irq_pkg::PROP_PACKET_EN:  return c.packet_en;
            radio_irq_pkg::PROP_MODEM_EN:   return c.modem_en;
            radio_irq_pkg::PROP_CHIP_EN:    return c.chip_en;
            radio_irq_pkg::PROP_MODULATION: return c.modulation;
            default:                        return 8'h00;
        endcase
    endfunction

    function automatic logic pin_level(input core_t c, input logic [5:0] fn, input logic ok);
        case (fn)
            radio_irq_pkg::PIN_DRIVE1: return 1'b1;
            radio_irq_pkg::PIN_POR:    return c.por_done;
            radio_irq_pkg::PIN_CTS:    return ok;
            radio_irq_pkg::PIN_EVENT:  return c.event_n;
            default:                   return 1'b0;
        endcase
    endfunction

    // Command acceptance follows the sequencer directly
    assign cts = ~i_seq_busy;

    always_comb begin
        logic [7:0]  pend_groups;
        logic [7:0]  live_groups;
        logic [15:0] addr;
        logic        clr_packet;
        logic        clr_modem;
        logic        clr_chip;
        logic        any_event;
        pend_groups = {5'h00, |core_reg.chip_pend, |core_reg.modem_pend, |core_reg.packet_pend};
        live_groups = {5'h00, |i_chip_status, |i_modem_status, |i_packet_status};
        addr        = 16'h0000;
        clr_packet  = 1'b0;
        clr_modem   = 1'b0;
        clr_chip    = 1'b0;
        any_event   = 1'b0;

        core_next          = core_reg;
        core_next.gpio_s1  = i_gpio;
        core_next.gpio_s2  = core_reg.gpio_s1;
        core_next.sdn_s1   = i_shutdown_pin;
        core_next.sdn_s2   = core_reg.sdn_s1;
        core_next.cs_s1    = i_cs_n;
        core_next.cs_s2    = core_reg.cs_s1;
        core_next.cnt_s1   = rx_gray;
        core_next.cnt_s2   = core_reg.cnt_s1;
        core_next.por_done = 1'b1;
        core_next.resp[radio_irq_pkg::IDX_CTS] = cts ? 8'hff : 8'h00;

        if (core_reg.cs_s2) begin
            core_next.idx  = 4'h0;
            core_next.done = 4'h0;
        end else if (core_reg.cnt_s2 != core_reg.done) begin
            // The link holds this byte until the next byte or the frame end, longer than the crossing
            core_next.done = radio_irq_pkg::bin2gray(radio_irq_pkg::gray2bin(core_reg.done) + 4'h1);
            core_next.idx  = core_reg.idx + 4'h1;
            if (core_reg.idx == 4'h0) begin
                core_next.cmd = cts ? rx_byte : radio_irq_pkg::CMD_NONE;
                for (int i = 2; i < 16; i++) begin
                    core_next.resp[i] = 8'h00;
                end
                if (cts) begin
                    case (rx_byte)
                        radio_irq_pkg::CMD_READ_ALL: begin
                            core_next.resp[2] = pend_groups;
                            core_next.resp[3] = live_groups;
                            core_next.resp[4] = core_reg.packet_pend;
                            core_next.resp[5] = i_packet_status;
                            core_next.resp[6] = core_reg.modem_pend;
                            core_next.resp[7] = i_modem_status;
                            core_next.resp[8] = core_reg.chip_pend;
                            core_next.resp[9] = i_chip_status;
                            clr_packet = 1'b1;
                            clr_modem  = 1'b1;
                            clr_chip   = 1'b1;
                        end
                        radio_irq_pkg::CMD_READ_PACKET: begin
                            core_next.resp[2] = core_reg.packet_pend;
                            core_next.resp[3] = i_packet_status;
                            clr_packet = 1'b1;
                        end
                        radio_irq_pkg::CMD_READ_MODEM: begin
                            core_next.resp[2] = core_reg.modem_pend;
                            core_next.resp[3] = i_modem_status;
                            clr_modem = 1'b1;
                        end
                        radio_irq_pkg::CMD_READ_CHIP: begin
                            core_next.resp[2] = core_reg.chip_pend;
                            core_next.resp[3] = i_chip_status;
                            clr_chip = 1'b1;
                        end
                        radio_irq_pkg::CMD_QUICK_STATUS: begin
                            // Report only; latches and the pin are left alone
                            core_next.resp[2] = core_reg.packet_pend;
                            core_next.resp[3] = core_reg.modem_pend;
                            core_next.resp[4] = core_reg.chip_pend;
                            core_next.resp[5] = pend_groups;
                        end
                        default: begin
                        end
                    endcase
                end
            end else begin
                if (core_reg.idx == 4'h1) begin
                    core_next.grp = rx_byte;
                end
                if (core_reg.idx == radio_irq_pkg::IDX_START) begin
                    core_next.start = rx_byte;
                    if (core_reg.cmd == radio_irq_pkg::CMD_GET_PROP) begin
                        for (int i = 0; i < 4; i++) begin
                            core_next.resp[radio_irq_pkg::IDX_PROP_DATA + 4'(i)] =
                                prop_read(core_reg, {core_reg.grp, rx_byte + 8'(i)});
                        end
                    end
                end
                case (core_reg.cmd)
                    radio_irq_pkg::CMD_PIN_CFG: begin
                        if (core_reg.idx < radio_irq_pkg::IDX_DRIVE) begin
                            core_next.pin_fn[core_reg.idx[1:0] - 2'h1] = rx_byte[5:0];
                        end else if (core_reg.idx == radio_irq_pkg::IDX_DRIVE) begin
                            core_next.drive = rx_byte[radio_irq_pkg::DRIVE_MSB:radio_irq_pkg::DRIVE_LSB];
                        end
                    end
                    radio_irq_pkg::CMD_SET_PROP: begin
                        if (core_reg.idx >= radio_irq_pkg::IDX_WDATA) begin
                            addr = {core_reg.grp,
                                    core_reg.start + {4'h0, core_reg.idx - radio_irq_pkg::IDX_WDATA}};
                            case (addr)
                                radio_irq_pkg::PROP_GROUP_EN:   core_next.group_en   = rx_byte;
                                radio_irq_pkg::PROP_PACKET_EN:  core_next.packet_en  = rx_byte;
                                radio_irq_pkg::PROP_MODEM_EN:   core_next.modem_en   = rx_byte;
                                radio_irq_pkg::PROP_CHIP_EN:    core_next.chip_en    = rx_byte;
                                radio_irq_pkg::PROP_MODULATION: core_next.modulation = rx_byte;
                                default: begin
                                end
                            endcase
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        // A new event in the clearing cycle survives the clear
        core_next.packet_pend = (core_reg.packet_pend & ~{8{clr_packet}}) | i_packet_event;
        core_next.modem_pend  = (core_reg.modem_pend & ~{8{clr_modem}}) | i_modem_event;
        core_next.chip_pend   = (core_reg.chip_pend & ~{8{clr_chip}}) | i_chip_event;

        any_event = ((|(core_reg.packet_pend & core_reg.packet_en)) & core_reg.group_en[radio_irq_pkg::GRP_PACKET_BIT])
                  | ((|(core_reg.modem_pend & core_reg.modem_en)) & core_reg.group_en[radio_irq_pkg::GRP_MODEM_BIT])
                  | ((|(core_reg.chip_pend & core_reg.chip_en)) & core_reg.group_en[radio_irq_pkg::GRP_CHIP_BIT]);
        core_next.event_n = ~any_event;

        for (int p = 0; p < 4; p++) begin
            core_next.gpio_out[p]  = pin_level(core_reg, core_reg.pin_fn[p], cts);
            core_next.gpio_oe_n[p] = (core_reg.pin_fn[p] == radio_irq_pkg::PIN_TRISTATE)
                                   | (core_reg.pin_fn[p] == radio_irq_pkg::PIN_INPUT);
        end

        // Shutdown loses all settings; only the synchronisers keep running
        if (core_reg.sdn_s2) begin
            core_next           = CORE_RST;
            core_next.gpio_s1   = i_gpio;
            core_next.gpio_s2   = core_reg.gpio_s1;
            core_next.sdn_s1    = i_shutdown_pin;
            core_next.sdn_s2    = core_reg.sdn_s1;
            core_next.cs_s1     = i_cs_n;
            core_next.cs_s2     = core_reg.cs_s1;
            core_next.cnt_s1    = rx_gray;
            core_next.cnt_s2    = core_reg.cnt_s1;
            core_next.gpio_out  = 4'h0;
            core_next.gpio_oe_n = 4'h0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            core_reg <= CORE_RST;
        end else begin
            core_reg <= core_next;
        end
    end

    assign o_event_out_n     = core_reg.event_n;
    assign o_event_out_oe_n  = core_reg.sdn_s2;
    assign o_serial_out_oe_n = core_reg.sdn_s2 | i_cs_n;
    assign o_gpio            = core_reg.gpio_out;
    assign o_gpio_oe_n       = core_reg.gpio_oe_n;
    assign o_gpio_drive      = core_reg.drive;
    assign o_cts             = cts;

    assign o_keying_scheme   = core_reg.modulation[radio_irq_pkg::KEY_MSB:radio_irq_pkg::KEY_LSB];
    assign o_tx_data_origin  = core_reg.modulation[radio_irq_pkg::ORIGIN_MSB:radio_irq_pkg::ORIGIN_LSB];
    assign o_tx_direct_pin   = core_reg.modulation[radio_irq_pkg::DPIN_MSB:radio_irq_pkg::DPIN_LSB];
    assign o_tx_direct_async = core_reg.modulation[radio_irq_pkg::DASYNC_BIT];
    // Data pin only feeds the modulator in direct mode
    assign o_tx_direct_data  = (o_tx_data_origin == radio_irq_pkg::ORIGIN_DIRECT)
                             & core_reg.gpio_s2[o_tx_direct_pin];
    assign o_mod_unsupported = (o_keying_scheme > radio_irq_pkg::KEY_GFSK4)
                             | (o_tx_data_origin == 2'h3)
                             | (o_tx_direct_async & (o_tx_data_origin == radio_irq_pkg::ORIGIN_DIRECT)
                                & ((o_keying_scheme == radio_irq_pkg::KEY_GFSK2)
                                 | (o_keying_scheme == radio_irq_pkg::KEY_GFSK4)));
endmodule

// ==== verification/radio_irq_gpio_mod_config_checker.sv ====
// Port assertions for the radio event, pin and modulation block
`timescale 1ns/1ps
module radio_irq_gpio_mod_config_checker (
    input wire logic       i_clk, i_rst, i_shutdown_pin, i_seq_busy, o_cts, o_event_out_n,
    input wire logic       o_event_out_oe_n, o_serial_out_oe_n, o_tx_direct_async, o_tx_direct_data,
    input wire logic       o_mod_unsupported,
    input wire logic [1:0] o_gpio_drive, o_tx_data_origin, o_tx_direct_pin,
    input wire logic [2:0] o_keying_scheme,
    input wire logic [3:0] o_gpio, o_gpio_oe_n
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Sync and output flops first
    sequence sd_held;
        i_shutdown_pin [*5];
    endsequence
    chk_cts_busy: assert property (o_cts == !i_seq_busy)
        else $error("accept flag not inverse of busy");
    chk_irq_reset: assert property ($past(i_rst) |-> o_event_out_n)
        else $error("event pin low after reset");
    chk_drive_min: assert property ($past(i_rst) |-> o_gpio_drive == 2'h0)
        else $error("drive strength not minimum after reset");
    chk_mod_reset: assert property ($past(i_rst) |->
        {o_tx_direct_async, o_tx_direct_pin, o_tx_data_origin, o_keying_scheme} == 8'h02)
        else $error("modulation fields wrong after reset");
    chk_reserved_flag: assert property (o_mod_unsupported == (o_keying_scheme > 3'h5 || o_tx_data_origin == 2'h3 ||
        (o_tx_direct_async && o_tx_data_origin == 2'h1 && o_keying_scheme[0] && o_keying_scheme != 3'h1)))
        else $error("unsupported flag wrong");
    chk_direct_idle: assert property (o_tx_data_origin != 2'h1 [*2] |-> !o_tx_direct_data)
        else $error("direct data active outside direct mode");
    chk_sd_pins: assert property (sd_held |-> o_gpio == 4'h0 && o_gpio_oe_n == 4'h0)
        else $error("pins not driven low in shutdown");
    chk_sd_release: assert property (sd_held |-> o_event_out_oe_n && o_serial_out_oe_n)
        else $error("event or serial pin driven in shutdown");
endmodule

// ==== verification/radio_host_model.sv ====
// Host controller model driving serial command frames
`timescale 1ns/1ps
module radio_host_model (
    output logic      o_sclk,  // Serial clock, still outside frames
    output logic      o_cs_n,  // Frame select
    output logic      o_sdi,   // Data to device
    input  wire logic i_sdo,   // Data from device, pulled up
    input  wire logic i_cts    // Command-accept flag
);
    logic [7:0] tx_q[$], rx_q[$];
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi = 1'b0;
    end
    task automatic frame(input int n);
        logic [7:0] b;
        wait (i_cts);
        o_cs_n = 1'b0;
        rx_q = {};
        repeat (n) begin
            b = tx_q.size() ? tx_q.pop_front() : 8'h00;
            for (int i = 7; i >= 0; i--) begin
                o_sdi = b[i];
                #40 b[i] = i_sdo;
                o_sclk = 1'b1;
                #80 o_sclk = 1'b0;
                #40;
            end
            rx_q.push_back(b);
        end
        o_cs_n = 1'b1;
        #200;
    endtask
endmodule

// ==== verification/radio_irq_gpio_mod_config_bench.sv ====
// Self-checking bench for the radio event, pin and modulation block
`timescale 1ns/1ps
module radio_irq_gpio_mod_config_bench;
    logic       clk, rst, busy, sd, sclk, csn, serial_in_pin, serial_out_pin, soe_n, irq_n, ioe_n, cts, das, ddat, uns;
    logic [7:0] ev[3], st[3], v;
    logic [3:0] gdrv, gin, go, goe_n;
    logic [2:0] key;
    logic [1:0] drv, org, dpin;
    int         err_count, compares, seed, pend[3], en[3], grp;
    // Released event and serial-out pins float to the pull-up level; released GPIO pins read gdrv
    wire        irq_w = ioe_n ? 1'b1 : irq_n;
    wire        sdo_w = soe_n ? 1'b1 : serial_out_pin;
    assign gin = (~goe_n & go) | (goe_n & gdrv);
    radio_irq_gpio_mod_config DUT (.i_clk(clk), .i_rst(rst), .i_sclk(sclk), .i_cs_n(csn), .i_serial_in_pin(serial_in_pin),
        .o_serial_out_pin(serial_out_pin), .o_serial_out_oe_n(soe_n), .i_shutdown_pin(sd), .i_seq_busy(busy),
        .i_packet_event(ev[0]), .i_modem_event(ev[1]), .i_chip_event(ev[2]), .i_packet_status(st[0]),
        .i_modem_status(st[1]), .i_chip_status(st[2]), .o_event_out_n(irq_n), .o_event_out_oe_n(ioe_n),
        .i_gpio(gin), .o_gpio(go), .o_gpio_oe_n(goe_n), .o_gpio_drive(drv), .o_cts(cts), .o_keying_scheme(key),
        .o_tx_data_origin(org), .o_tx_direct_pin(dpin), .o_tx_direct_async(das), .o_tx_direct_data(ddat),
        .o_mod_unsupported(uns));
    radio_host_model host (.o_sclk(sclk), .o_cs_n(csn), .o_sdi(serial_in_pin), .i_sdo(sdo_w), .i_cts(cts));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic setp(input logic [15:0] a, input logic [7:0] d);
        host.tx_q = '{radio_irq_pkg::CMD_SET_PROP, a[15:8], 8'h01, a[7:0], d};
        host.frame(5);
    endtask
    task automatic fire;
        @(posedge clk);
        foreach (ev[g]) begin
            v = $random(seed);
            ev[g] <= v;
            pend[g] |= v;
        end
        @(posedge clk);
        foreach (ev[g]) ev[g] <= 8'h00;
        repeat (2) @(negedge clk);
    endtask
    function automatic logic exp_irq;
        exp_irq = 1'b1;
        foreach (pend[g]) if (grp[g] && (pend[g] & en[g]) != 0) exp_irq = 1'b0;
    endfunction
    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #2000000 err_count++;
        final_report;
    end
    initial begin
        seed = 46767;
        {rst, busy, sd, gdrv} = 7'h40;
        foreach (st[g]) st[g] = $random(seed);
        foreach (ev[g]) ev[g] = 8'h00;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(negedge clk);
        check("pins", {4'h0, go}, 8'h0f);
        host.tx_q = '{radio_irq_pkg::CMD_GET_PROP, 8'h01, 8'h00, 8'h00};
        host.frame(9);
        foreach (en[g]) check("dflt", host.rx_q[6+g], (g == 2) ? 8'h04 : 8'h00);
        check("dflt", host.rx_q[5], 8'h04);
        grp = $random(seed) & 7;
        setp(radio_irq_pkg::PROP_GROUP_EN, grp[7:0]);
        foreach (en[g]) begin
            en[g] = $random(seed) & 255;
            setp(radio_irq_pkg::PROP_PACKET_EN + 16'(g), en[g][7:0]);
        end
        for (int k = 0; k < 3; k++) begin
            @(posedge clk) {busy, st[0], st[1], st[2]} <= {1'b1, 24'($random(seed))};
            fork begin repeat (5) @(posedge clk); busy <= 1'b0; end join_none
            fire;
            check("irq", {7'h0, irq_w}, {7'h0, exp_irq()});
            host.tx_q = '{radio_irq_pkg::CMD_QUICK_STATUS};
            host.frame(6);
            foreach (pend[g]) check("quick", host.rx_q[2+g], pend[g][7:0]);
            check("irq", {7'h0, irq_w}, {7'h0, exp_irq()});
            host.tx_q = '{8'h21 + 8'(k)};
            host.frame(4);
            check("grp", host.rx_q[2], pend[k][7:0]);
            check("live", host.rx_q[3], st[k]);
            pend[k] = 0;
            check("irq", {7'h0, irq_w}, {7'h0, exp_irq()});
        end
        fire;
        repeat (2) begin
            host.tx_q = '{8'h20};
            host.frame(10);
            check("pg", host.rx_q[2], {5'h0, |pend[2], |pend[1], |pend[0]});
            foreach (pend[g]) begin
                check("all", host.rx_q[4+2*g], pend[g][7:0]);
                check("live", host.rx_q[5+2*g], st[g]);
                pend[g] = 0;
            end
        end
        v = $random(seed);
        host.tx_q = '{8'h13, 8'h04, 8'h03, 8'h02, 8'h01, v};
        host.frame(6);
        check("cfg", {3'h0, goe_n[3:1], go[2:1]}, 8'h11);
        check("drive", {6'h0, drv}, {6'h0, v[6:5]});
        for (int k = 0; k < 4; k++) begin
            v = (k == 3) ? 8'h08 : (k == 2) ? 8'h8b : 8'($random(seed));
            setp(radio_irq_pkg::PROP_MODULATION, v);
            check("mod", {das, dpin, org, key}, v);
            check("uns", {7'h0, uns}, {7'h0, v[2:0] > 5 || v[4:3] == 3 ||
                v[7] && v[4:3] == 1 && v[0] && v[2:0] != 1});
        end
        repeat (4) begin
            @(posedge clk);
            gdrv <= 4'($random(seed));
            repeat (4) @(negedge clk);
            check("direct", {7'h0, ddat}, {7'h0, gdrv[0]});
        end
        @(posedge clk) sd <= 1'b1;
        repeat (8) @(negedge clk);
        check("sdn", {goe_n, go}, 8'h00);
        final_report;
    end
endmodule
bind radio_irq_gpio_mod_config radio_irq_gpio_mod_config_checker chk (.*);
